// ### shared/nbs_pkg.sv
// Constants, register map and state codes for the net busy sensing block
package nbs_pkg;
  // Clock and time units
  localparam int CLK_PERIOD_NS = 8;
  localparam int US_NS = 1000;
  localparam int CYC_PER_US = US_NS / CLK_PERIOD_NS;
  localparam logic [6:0] PRE_LAST = 7'(CYC_PER_US - 1);
  localparam int US_PER_S = 1000000;
  // Busy-detect limits per mode, in bit times and milliseconds
  localparam int SYNC_BIT_TIMES = 32;
  localparam int ASYNC_BIT_TIMES = 64;
  localparam int PACKET_B_MS = 250;
  localparam logic [43:0] SYNC_LIMIT = 44'(SYNC_BIT_TIMES * US_PER_S);
  localparam logic [43:0] ASYNC_LIMIT = 44'(ASYNC_BIT_TIMES * US_PER_S);
  localparam logic [19:0] PACKET_B_US = 20'(PACKET_B_MS * 1000);
  // Acknowledgment field lengths in bits
  localparam logic [9:0] ACK_SYNC_BITS = 10'h040;
  localparam logic [9:0] ACK_HDR_BITS = 10'h0A8;
  localparam logic [9:0] ACK_BODY_PLAIN = 10'h050;
  localparam logic [9:0] ACK_BODY_FEC = 10'h0A8;
  localparam logic [9:0] ACK_BODY_FEC_TDC = 10'h180;
  // Turnaround range in milliseconds
  localparam logic [6:0] TURN_MAX_MS = 7'h64;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MI_LEN = 8'h04;
  localparam logic [7:0] REG_TURN = 8'h08;
  localparam logic [7:0] REG_TOL = 8'h0C;
  localparam logic [7:0] REG_SMALLEST_PAIR_DELAY = 8'h10;
  localparam logic [7:0] REG_MINPAIR = 8'h14;
  localparam logic [7:0] REG_EQUIPMENT_PREAMBLE_TIME = 8'h18;
  localparam logic [7:0] REG_EQUIPMENT_LAG_TIME = 8'h1C;
  localparam logic [7:0] REG_BDET = 8'h20;
  localparam logic [7:0] REG_RHD = 8'h24;
  localparam logic [7:0] REG_TP = 8'h28;
  localparam logic [7:0] REG_NAD = 8'h2C;
  localparam logic [7:0] REG_STATUS = 8'h30;
  localparam logic [7:0] REG_ACKLEN = 8'h34;
  localparam logic [7:0] REG_WINDOW = 8'h38;
  // Control field positions
  localparam int CTRL_FEC = 0;
  localparam int CTRL_TDC = 1;
  localparam int CTRL_MI = 2;
  localparam int CTRL_VOICE = 3;
  localparam int CTRL_SMALLEST_PAIR_DELAY_KNOWN = 4;
  localparam int CTRL_MULTIDWELL = 5;
  localparam int CTRL_CONV = 6;
  localparam int CTRL_MODE_LO = 8;
  localparam int CTRL_W = 10;
  localparam logic [9:0] CTRL_RESET = 10'h000;
  localparam logic [19:0] TIME_RESET = 20'h00000;
  // Transfer modes
  typedef enum logic [1:0] {
    MODE_SYNC = 2'b00,
    MODE_ASYNC = 2'b01,
    MODE_PACKET = 2'b10,
    MODE_RSVD = 2'b11
  } nbs_mode_e;
  // Access sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_BUSY = 3'b001,
    ST_RHD = 3'b010,
    ST_ACK = 3'b011,
    ST_TP = 3'b100,
    ST_NAD = 3'b101
  } nbs_state_e;
endpackage

// ### src/nbs_us_timer.sv
// Microsecond down-counter used for windows and access delays
`timescale 1ns/1ps
`default_nettype none
module nbs_us_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic start,
  input wire logic stop,
  input wire logic [21:0] load_us,
  // Status
  output logic running,
  output logic done
);
  logic [6:0] pre; // Cycles within current microsecond
  logic [21:0] remain; // Microseconds left
  wire tick = running && (pre == nbs_pkg::PRE_LAST);
  wire last = remain <= 22'h000001;

  // Stop beats start so an abort is never overridden
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      running <= 1'b0;
      done <= 1'b0;
      pre <= 7'h00;
      remain <= 22'h000000;
    end
    else if (stop)
    begin
      running <= 1'b0;
      done <= 1'b0;
    end
    else if (start)
    begin
      running <= 1'b1;
      done <= 1'b0;
      pre <= 7'h00;
      remain <= load_us;
    end
    else
    begin
      done <= tick && last;
      pre <= tick ? 7'h00 : (running ? pre + 7'h01 : pre);
      remain <= tick ? remain - 22'h000001 : remain;
      running <= running && !(tick && last);
    end
  end
endmodule
`default_nettype wire

// ### src/nbs_net_access.sv
// Net access timing parameters, busy sensing and transmit gating
// How it works
// - Ack length counts 64-bit sync field
// - Ack length adds crypto indicator when sent
// - Ack length adds 168-bit word count block
// - Body 80, 168 or 384 by coding
// - Lengths valid only without multidwell/convolutional
// - Turnaround 0 to 100 ms, 1 ms steps
// - Pair delay term capped at net minimum
// - Unknown pair delay term counts as zero
// - Busy, hold, timeout and access delay exist
// - Data busy detected within fixed window
// - Sync mode busy-detect at most 32/n
// - Async mode busy-detect at most 64/n
// - Packet mode busy-detect at most 250 ms
// - Detected data busy sets busy indicator
// - Busy suppresses every transmission and ack
// - Busy clears only on physical idle
// - No voice detect means never voice busy
// - Window is preamble+lag+detect+tolerance
`timescale 1ns/1ps
`default_nettype none
module nbs_net_access (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Configuration
  input wire logic [23:0] link_bit_rate,
  // Radio side indications
  input wire logic rx_signal,
  input wire logic rx_data_detect,
  input wire logic voice_busy,
  input wire logic phy_idle,
  // Link layer requests
  input wire logic tx_req,
  input wire logic ack_req,
  input wire logic tx_done,
  input wire logic ack_expected,
  // Results
  output logic net_busy,
  output logic tx_grant,
  output logic ack_grant,
  output logic [9:0] ack_bits,
  output logic ack_len_valid,
  output logic [6:0] turnaround_ms,
  output logic [21:0] busy_window_us
);
  // Busy-detect value fits the limit for mode and rate
  function automatic logic b_fits(input logic [19:0] b,
                                  input logic [23:0] n,
                                  input logic [1:0] mode);
    logic [43:0] prod;
    prod = 44'(b) * 44'(n);
    if (mode == nbs_pkg::MODE_SYNC)
      b_fits = prod <= nbs_pkg::SYNC_LIMIT;
    else if (mode == nbs_pkg::MODE_ASYNC)
      b_fits = prod <= nbs_pkg::ASYNC_LIMIT;
    else
      b_fits = b <= nbs_pkg::PACKET_B_US;
  endfunction

  // Smaller of two microsecond values
  function automatic logic [19:0] min20(input logic [19:0] a,
                                        input logic [19:0] b);
    min20 = (a < b) ? a : b;
  endfunction

  // Software registers
  logic [9:0] ctrl; // Coding, options and mode
  logic [7:0] mi_len; // Crypto indicator field bits
  logic [19:0] tol_base; // Tolerance base, us
  logic [19:0] smallest_pair_delay; // Smallest pair delay, us
  logic [19:0] min_pair; // Net minimum pair delay, us
  logic [19:0] equipment_preamble_time; // Equipment preamble, us
  logic [19:0] equipment_lag_time; // Equipment lag, us
  logic [19:0] bdet; // Busy-detect parameter, us
  logic [19:0] response_hold_delay; // Response hold delay, us
  logic [19:0] tp; // Timeout period, us
  logic [19:0] network_access_delay; // Network access delay, us
  // Internal state
  nbs_pkg::nbs_state_e state;
  nbs_pkg::nbs_state_e next_state;
  logic rx_signal_q; // For edge of signal energy
  logic win_run;
  logic win_done;
  logic acc_run;
  logic acc_done;

  // Control field decode
  wire fec_en = ctrl[nbs_pkg::CTRL_FEC];
  wire tdc_en = ctrl[nbs_pkg::CTRL_TDC];
  wire mi_en = ctrl[nbs_pkg::CTRL_MI];
  wire voice_avail = ctrl[nbs_pkg::CTRL_VOICE];
  wire smallest_pair_delay_known = ctrl[nbs_pkg::CTRL_SMALLEST_PAIR_DELAY_KNOWN];
  wire md_en = ctrl[nbs_pkg::CTRL_MULTIDWELL];
  wire conv_en = ctrl[nbs_pkg::CTRL_CONV];
  wire [1:0] mode = ctrl[nbs_pkg::CTRL_MODE_LO +: 2];

  // Ack length terms; TIME_DISPERSAL_CODING without FEC counts as plain
  wire [9:0] body_bits = (fec_en && tdc_en) ? nbs_pkg::ACK_BODY_FEC_TDC :
                         fec_en ? nbs_pkg::ACK_BODY_FEC :
                         nbs_pkg::ACK_BODY_PLAIN;
  wire [9:0] mi_bits = mi_en ? {2'b00, mi_len} : 10'h000;
  wire [9:0] next_ack_bits = nbs_pkg::ACK_SYNC_BITS + mi_bits +
                             nbs_pkg::ACK_HDR_BITS + body_bits;

  // Pair delay term, capped and zeroed when unknown
  wire [19:0] smallest_pair_delay_eff = smallest_pair_delay_known ? min20(smallest_pair_delay, min_pair)
                                    : nbs_pkg::TIME_RESET;
  wire [19:0] tol_us = tol_base + smallest_pair_delay_eff;
  // Over-limit detect value falls back to zero: stricter, never looser
  wire b_ok = b_fits(bdet, link_bit_rate, mode);
  wire [19:0] b_eff = b_ok ? bdet : nbs_pkg::TIME_RESET;
  wire [21:0] next_window = 22'(equipment_preamble_time) + 22'(equipment_lag_time) + 22'(b_eff) +
                            22'(tol_us);

  // Busy set and clear terms
  wire voice_eff = voice_avail && voice_busy;
  wire busy_set = rx_data_detect || voice_eff || win_done;
  wire busy_clr = net_busy && phy_idle && !busy_set;
  wire next_busy = busy_set || (net_busy && !busy_clr);

  // Window runs from start of signal energy until busy is set or the energy drops
  wire win_start = rx_signal && !rx_signal_q && !net_busy;
  wire win_stop = busy_set || !rx_signal;

  // Access sequencer transitions
  always_comb
  begin
    next_state = state;
    if (busy_set)
      next_state = nbs_pkg::ST_BUSY;
    else
    begin
      case (state)
        nbs_pkg::ST_BUSY:
          if (busy_clr)
            next_state = ack_req ? nbs_pkg::ST_RHD : nbs_pkg::ST_NAD;
        nbs_pkg::ST_RHD:
          if (acc_done)
            next_state = nbs_pkg::ST_ACK;
        nbs_pkg::ST_ACK:
          if (!ack_req)
            next_state = nbs_pkg::ST_NAD;
        nbs_pkg::ST_TP:
          if (acc_done)
            next_state = nbs_pkg::ST_NAD;
        nbs_pkg::ST_NAD:
          if (acc_done)
            next_state = nbs_pkg::ST_IDLE;
        default:
          if (ack_req)
            next_state = nbs_pkg::ST_RHD;
          else if (tx_done)
            next_state = ack_expected ? nbs_pkg::ST_TP : nbs_pkg::ST_NAD;
      endcase
    end
  end

  // Access timer loads on entry to each delay state
  wire acc_start = (next_state != state) &&
                   ((next_state == nbs_pkg::ST_RHD) ||
                    (next_state == nbs_pkg::ST_TP) ||
                    (next_state == nbs_pkg::ST_NAD));
  wire [21:0] acc_load = (next_state == nbs_pkg::ST_RHD) ? 22'(response_hold_delay) :
                         (next_state == nbs_pkg::ST_TP) ? 22'(tp) :
                         22'(network_access_delay);
  wire acc_stop = busy_set;

  // Grants drop in the same cycle busy is raised
  wire quiet = !net_busy && !busy_set;
  wire next_tx_grant = quiet && tx_req && !ack_req &&
                       (state == nbs_pkg::ST_IDLE);
  wire next_ack_grant = quiet && ack_req &&
                        (state == nbs_pkg::ST_ACK);

  // Register write decode
  wire wr_ctrl = reg_wr && (reg_addr == nbs_pkg::REG_CTRL);
  wire wr_mi = reg_wr && (reg_addr == nbs_pkg::REG_MI_LEN);
  wire wr_turn = reg_wr && (reg_addr == nbs_pkg::REG_TURN);
  wire wr_tol = reg_wr && (reg_addr == nbs_pkg::REG_TOL);
  wire wr_smallest_pair_delay = reg_wr && (reg_addr == nbs_pkg::REG_SMALLEST_PAIR_DELAY);
  wire wr_minp = reg_wr && (reg_addr == nbs_pkg::REG_MINPAIR);
  wire wr_equipment_preamble_time = reg_wr && (reg_addr == nbs_pkg::REG_EQUIPMENT_PREAMBLE_TIME);
  wire wr_equipment_lag_time = reg_wr && (reg_addr == nbs_pkg::REG_EQUIPMENT_LAG_TIME);
  wire wr_bdet = reg_wr && (reg_addr == nbs_pkg::REG_BDET);
  wire wr_rhd = reg_wr && (reg_addr == nbs_pkg::REG_RHD);
  wire wr_tp = reg_wr && (reg_addr == nbs_pkg::REG_TP);
  wire wr_nad = reg_wr && (reg_addr == nbs_pkg::REG_NAD);
  // Turnaround write saturates at the top of range
  wire [6:0] turn_in = (reg_wdata > 32'(nbs_pkg::TURN_MAX_MS)) ?
                       nbs_pkg::TURN_MAX_MS : reg_wdata[6:0];

  // Read selection; unmapped offsets read zero
  wire [31:0] status_word = {24'h000000, 1'b0, state, b_ok, win_run,
                             acc_run, net_busy};
  wire [31:0] rd_mux =
    (reg_addr == nbs_pkg::REG_CTRL) ? 32'(ctrl) :
    (reg_addr == nbs_pkg::REG_MI_LEN) ? 32'(mi_len) :
    (reg_addr == nbs_pkg::REG_TURN) ? 32'(turnaround_ms) :
    (reg_addr == nbs_pkg::REG_TOL) ? 32'(tol_base) :
    (reg_addr == nbs_pkg::REG_SMALLEST_PAIR_DELAY) ? 32'(smallest_pair_delay) :
    (reg_addr == nbs_pkg::REG_MINPAIR) ? 32'(min_pair) :
    (reg_addr == nbs_pkg::REG_EQUIPMENT_PREAMBLE_TIME) ? 32'(equipment_preamble_time) :
    (reg_addr == nbs_pkg::REG_EQUIPMENT_LAG_TIME) ? 32'(equipment_lag_time) :
    (reg_addr == nbs_pkg::REG_BDET) ? 32'(bdet) :
    (reg_addr == nbs_pkg::REG_RHD) ? 32'(response_hold_delay) :
    (reg_addr == nbs_pkg::REG_TP) ? 32'(tp) :
    (reg_addr == nbs_pkg::REG_NAD) ? 32'(network_access_delay) :
    (reg_addr == nbs_pkg::REG_STATUS) ? status_word :
    (reg_addr == nbs_pkg::REG_ACKLEN) ? {21'h000000, ack_len_valid,
                                         ack_bits} :
    (reg_addr == nbs_pkg::REG_WINDOW) ? 32'(busy_window_us) :
    32'h00000000;

  // Configuration registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl <= nbs_pkg::CTRL_RESET;
      mi_len <= 8'h00;
      turnaround_ms <= 7'h00;
      tol_base <= nbs_pkg::TIME_RESET;
      smallest_pair_delay <= nbs_pkg::TIME_RESET;
      min_pair <= nbs_pkg::TIME_RESET;
    end
    else
    begin
      if (wr_ctrl) ctrl <= reg_wdata[nbs_pkg::CTRL_W-1:0];
      if (wr_mi) mi_len <= reg_wdata[7:0];
      if (wr_turn) turnaround_ms <= turn_in;
      if (wr_tol) tol_base <= reg_wdata[19:0];
      if (wr_smallest_pair_delay) smallest_pair_delay <= reg_wdata[19:0];
      if (wr_minp) min_pair <= reg_wdata[19:0];
    end
  end

  // Timing parameter registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      equipment_preamble_time <= nbs_pkg::TIME_RESET;
      equipment_lag_time <= nbs_pkg::TIME_RESET;
      bdet <= nbs_pkg::TIME_RESET;
      response_hold_delay <= nbs_pkg::TIME_RESET;
      tp <= nbs_pkg::TIME_RESET;
      network_access_delay <= nbs_pkg::TIME_RESET;
    end
    else
    begin
      if (wr_equipment_preamble_time) equipment_preamble_time <= reg_wdata[19:0];
      if (wr_equipment_lag_time) equipment_lag_time <= reg_wdata[19:0];
      if (wr_bdet) bdet <= reg_wdata[19:0];
      if (wr_rhd) response_hold_delay <= reg_wdata[19:0];
      if (wr_tp) tp <= reg_wdata[19:0];
      if (wr_nad) network_access_delay <= reg_wdata[19:0];
    end
  end

  // Derived results, busy flag, grants and read data
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_bits <= 10'h000;
      ack_len_valid <= 1'b0;
      busy_window_us <= 22'h000000;
      net_busy <= 1'b0;
      tx_grant <= 1'b0;
      ack_grant <= 1'b0;
      rx_signal_q <= 1'b0;
      state <= nbs_pkg::ST_IDLE;
      reg_rdata <= 32'h00000000;
    end
    else
    begin
      ack_bits <= next_ack_bits;
      ack_len_valid <= !md_en && !conv_en;
      busy_window_us <= next_window;
      net_busy <= next_busy;
      tx_grant <= next_tx_grant;
      ack_grant <= next_ack_grant;
      rx_signal_q <= rx_signal;
      state <= next_state;
      reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
    end
  end

  // Detection window timer
  nbs_us_timer u_win (
    .clk(clk),
    .rst_n(rst_n),
    .start(win_start),
    .stop(win_stop),
    .load_us(next_window),
    .running(win_run),
    .done(win_done)
  );

  // Hold, timeout and access delay timer
  nbs_us_timer u_acc (
    .clk(clk),
    .rst_n(rst_n),
    .start(acc_start),
    .stop(acc_stop),
    .load_us(acc_load),
    .running(acc_run),
    .done(acc_done)
  );

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_clear_with_ack;
    state == nbs_pkg::ST_BUSY && busy_clr && ack_req;
  endsequence

  AST_ACK_PLAIN: assert property (
    (!fec_en && !mi_en) |=> ack_bits ==
      10'(nbs_pkg::ACK_SYNC_BITS + nbs_pkg::ACK_HDR_BITS +
          nbs_pkg::ACK_BODY_PLAIN))
    else $error("plain ack length wrong");
  AST_ACK_MI: assert property (
    (mi_en && fec_en && tdc_en) |=> ack_bits == 10'(nbs_pkg::ACK_SYNC_BITS
      + nbs_pkg::ACK_HDR_BITS + nbs_pkg::ACK_BODY_FEC_TDC + $past(mi_len)))
    else $error("ack length misses indicator");
  AST_ACK_VALID: assert property (
    (md_en || conv_en) |=> !ack_len_valid)
    else $error("ack length valid under multidwell or conv");
  AST_TURN_SAT: assert property (
    (wr_turn && reg_wdata > 32'(nbs_pkg::TURN_MAX_MS)) |=>
      turnaround_ms == nbs_pkg::TURN_MAX_MS)
    else $error("turnaround not saturated");
  AST_SMALLEST_PAIR_DELAY_CAP: assert property (
    smallest_pair_delay_known ? (smallest_pair_delay_eff <= min_pair) : (smallest_pair_delay_eff == 20'h00000))
    else $error("pair delay term out of bound");
  AST_B_LIMIT: assert property (
    (b_eff != nbs_pkg::TIME_RESET) |-> (mode[1] ?
      (b_eff <= nbs_pkg::PACKET_B_US) :
      ((44'(b_eff) * 44'(link_bit_rate)) <= (mode[0] ?
        nbs_pkg::ASYNC_LIMIT : nbs_pkg::SYNC_LIMIT))))
    else $error("busy-detect over mode limit");
  AST_DATA_BUSY: assert property (
    (rx_data_detect || win_done) |=> net_busy)
    else $error("data busy not flagged");
  AST_VOICE: assert property (
    (voice_busy && !voice_avail && !rx_data_detect && !win_done &&
     !net_busy) |=> !net_busy)
    else $error("voice busy without voice detection");
  AST_SUPPRESS: assert property (
    net_busy |=> !tx_grant && !ack_grant)
    else $error("grant while busy");
  AST_CLEAR: assert property (
    $fell(net_busy) |-> $past(phy_idle))
    else $error("busy cleared without idle");
  AST_WINDOW: assert property (
    $stable(next_window) [*2] |-> busy_window_us ==
      22'(equipment_preamble_time) + 22'(equipment_lag_time) + 22'(b_eff) + 22'(tol_us))
    else $error("window sum wrong");
  AST_HOLD: assert property (
    s_clear_with_ack |=> state == nbs_pkg::ST_RHD && acc_run && !ack_grant)
    else $error("hold delay not started");
endmodule
`default_nettype wire

// ### tb/nbs_radio_model.sv
// Behavioural radio equipment driving the receive and idle indications
`timescale 1ns/1ps
`default_nettype none
module nbs_radio_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Air activity: 0 quiet, 1 data, 2 voice, 3 bare carrier
  input wire logic [1:0] act,
  // Indications toward the block
  output logic rx_signal,
  output logic rx_data_detect,
  output logic voice_busy,
  output logic phy_idle
);
  // One cycle behind the air, as a real receiver would be
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_signal <= 1'b0;
      rx_data_detect <= 1'b0;
      voice_busy <= 1'b0;
      phy_idle <= 1'b1;
    end
    else
    begin
      rx_signal <= (act != 2'h0);
      rx_data_detect <= (act == 2'h1);
      voice_busy <= (act == 2'h2);
      // Carrier alone is not idle: energy may still turn into data
      phy_idle <= (act == 2'h0);
    end
  end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the net busy sensing block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // Stimulus and observed signals
  logic clk, rst_n, reg_wr, reg_rd, tx_req, ack_req, tx_done, ack_exp;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [23:0] link_bit_rate;
  logic [1:0] act;
  logic rx_signal, rx_data, voice_busy, phy_idle;
  logic net_busy, tx_grant, ack_grant, ack_len_valid;
  logic [9:0] ack_bits;
  logic [6:0] turn_ms;
  logic [21:0] win_us;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;

  nbs_net_access i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .link_bit_rate(link_bit_rate),
    .rx_signal(rx_signal), .rx_data_detect(rx_data), .voice_busy(voice_busy),
    .phy_idle(phy_idle), .tx_req(tx_req), .ack_req(ack_req),
    .tx_done(tx_done), .ack_expected(ack_exp), .net_busy(net_busy),
    .tx_grant(tx_grant), .ack_grant(ack_grant), .ack_bits(ack_bits),
    .ack_len_valid(ack_len_valid), .turnaround_ms(turn_ms),
    .busy_window_us(win_us));

  nbs_radio_model i_radio (.clk(clk), .rst_n(rst_n), .act(act),
    .rx_signal(rx_signal), .rx_data_detect(rx_data),
    .voice_busy(voice_busy), .phy_idle(phy_idle));

  // 125 MHz clock
  always #4 clk = ~clk;

  // Hang guard, well above the few thousand cycles the tests need
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      test_done();
    end
  end

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [43:0] got, input logic [43:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Let n edges land, then sample settled outputs
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Write one window term and compare the summed window
  task automatic wchk(input logic [7:0] a, input logic [31:0] v,
                      input logic [21:0] e);
    wr(a, v);
    step(2);
    chk(win_us, e);
  endtask

  task automatic drive_act(input logic [1:0] v);
    @(posedge clk);
    act <= v;
  endtask

  task automatic t_ack();
    logic [31:0] d;
    logic [9:0] e;
    chk(ack_bits, 44'h138);
    wr(nbs_pkg::REG_MI_LEN, 32'h00000010);
    // Every fec, tdc and indicator combination
    for (int c = 0; c < 8; c++)
    begin
      wr(nbs_pkg::REG_CTRL, 32'(c));
      step(2);
      e = (c[0] && c[1]) ? 10'h180 : (c[0] ? 10'h0A8 : 10'h050);
      e = e + 10'h040 + 10'h0A8 + (c[2] ? 10'h010 : 10'h000);
      chk(ack_bits, 44'(e));
      rd(nbs_pkg::REG_ACKLEN, d);
      chk(d, {33'h1, e});
    end
    wr(nbs_pkg::REG_CTRL, 32'h00000020);
    step(2);
    chk(ack_len_valid, 1'b0);
    wr(nbs_pkg::REG_CTRL, 32'h00000040);
    step(2);
    chk(ack_len_valid, 1'b0);
    wr(nbs_pkg::REG_CTRL, 32'h00000000);
    step(2);
    chk(ack_len_valid, 1'b1);
    $display("Test ack length done");
  endtask

  task automatic t_turn();
    logic [31:0] d;
    logic [31:0] wv [4] = '{32'h0, 32'h64, 32'h65, 32'hC8};
    logic [6:0] ev [4] = '{7'h00, 7'h64, 7'h64, 7'h64};
    for (int i = 0; i < 4; i++)
    begin
      wr(nbs_pkg::REG_TURN, wv[i]);
      step(1);
      chk(turn_ms, ev[i]);
      rd(nbs_pkg::REG_TURN, d);
      chk(d, 44'(ev[i]));
    end
    // Unmapped read and a write to a read-only place
    rd(8'h3C, d);
    chk(d, 44'h0);
    wr(nbs_pkg::REG_ACKLEN, 32'h0);
    rd(nbs_pkg::REG_ACKLEN, d);
    chk(d, 44'h538);
    $display("Test turnaround done");
  endtask

  task automatic t_window();
    logic [31:0] d;
    @(posedge clk);
    link_bit_rate <= 24'h7A1200;
    wr(nbs_pkg::REG_EQUIPMENT_PREAMBLE_TIME, 32'h3);
    wr(nbs_pkg::REG_EQUIPMENT_LAG_TIME, 32'h4);
    wr(nbs_pkg::REG_BDET, 32'h5);
    wr(nbs_pkg::REG_TOL, 32'h6);
    wr(nbs_pkg::REG_SMALLEST_PAIR_DELAY, 32'h7);
    wr(nbs_pkg::REG_MINPAIR, 32'h2);
    wchk(nbs_pkg::REG_CTRL, 32'h100, 22'h12);
    wchk(nbs_pkg::REG_CTRL, 32'h110, 22'h14);
    wchk(nbs_pkg::REG_CTRL, 32'h000, 22'h0D);
    @(posedge clk);
    link_bit_rate <= 24'h5B8D80;
    step(3);
    chk(win_us, 22'h12);
    wchk(nbs_pkg::REG_CTRL, 32'h200, 22'h12);
    wchk(nbs_pkg::REG_BDET, 32'h3D090, 22'h3D09D);
    wchk(nbs_pkg::REG_CTRL, 32'h300, 22'h3D09D);
    wchk(nbs_pkg::REG_BDET, 32'h3D091, 22'h0D);
    rd(nbs_pkg::REG_STATUS, d);
    chk(d[3], 1'b0);
    rd(nbs_pkg::REG_WINDOW, d);
    chk(d, 44'h0D);
    // Leave a 2 us window for the timeout test
    wr(nbs_pkg::REG_EQUIPMENT_PREAMBLE_TIME, 32'h0);
    wr(nbs_pkg::REG_EQUIPMENT_LAG_TIME, 32'h0);
    wr(nbs_pkg::REG_BDET, 32'h0);
    wchk(nbs_pkg::REG_TOL, 32'h2, 22'h2);
    $display("Test window done");
  endtask

  task automatic t_busy();
    logic [31:0] d;
    @(posedge clk);
    tx_req <= 1'b1;
    step(3);
    chk(tx_grant, 1'b1);
    drive_act(2'h1);
    step(3);
    chk(net_busy, 1'b1);
    chk(tx_grant, 1'b0);
    // Carrier left over: not idle, so busy must stay
    drive_act(2'h3);
    step(6);
    chk(net_busy, 1'b1);
    drive_act(2'h0);
    step(3);
    chk(net_busy, 1'b0);
    step(300);
    // Own send, then wait for acks, then access delay
    @(posedge clk);
    tx_done <= 1'b1;
    ack_exp <= 1'b1;
    tx_req <= 1'b0;
    @(posedge clk);
    tx_done <= 1'b0;
    rd(nbs_pkg::REG_STATUS, d);
    chk(d[6:4], 3'h4);
    step(150);
    rd(nbs_pkg::REG_STATUS, d);
    chk(d[6:4], 3'h5);
    step(200);
    rd(nbs_pkg::REG_STATUS, d);
    chk(d[6:4], 3'h0);
    // Bare carrier with no data: the window must expire
    drive_act(2'h3);
    step(240);
    chk(net_busy, 1'b0);
    step(20);
    chk(net_busy, 1'b1);
    drive_act(2'h0);
    step(300);
    $display("Test busy done");
  endtask

  task automatic t_voice();
    drive_act(2'h2);
    step(10);
    chk(net_busy, 1'b0);
    drive_act(2'h0);
    wr(nbs_pkg::REG_CTRL, 32'h008);
    drive_act(2'h2);
    step(3);
    chk(net_busy, 1'b1);
    drive_act(2'h0);
    step(3);
    chk(net_busy, 1'b0);
    step(300);
    $display("Test voice done");
  endtask

  task automatic t_ack_flow();
    logic [31:0] d;
    int n;
    drive_act(2'h1);
    step(3);
    @(posedge clk);
    ack_req <= 1'b1;
    step(3);
    chk(ack_grant, 1'b0);
    drive_act(2'h0);
    step(3);
    rd(nbs_pkg::REG_STATUS, d);
    chk(d[6:4], 3'h2);
    n = 0;
    while (ack_grant !== 1'b1 && n < 300)
    begin
      step(1);
      n++;
    end
    chk(ack_grant, 1'b1);
    drive_act(2'h1);
    step(3);
    chk(ack_grant, 1'b0);
    drive_act(2'h0);
    ack_req <= 1'b0;
    step(300);
    $display("Test ack flow done");
  endtask

  // Main sequence
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    link_bit_rate = 24'h0;
    act = 2'h0;
    tx_req = 1'b0;
    ack_req = 1'b0;
    tx_done = 1'b0;
    ack_exp = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    step(2);
    t_ack();
    t_turn();
    t_window();
    t_busy();
    t_voice();
    t_ack_flow();
    test_done();
  end
endmodule
`default_nettype wire
